// ==== psms_top.sv ====
// start-up configuration sampling and link mode selection, APB slave
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module psms_top
   import psms_pkg::*;
#(
   parameter int unsigned RST_EXT = psms_pkg::RST_EXT_CYC
) (
   input  wire logic              i_core_clk,   // 100 MHz core clock
   input  wire logic              i_rstn,       // async reset, active low
   // apb slave
   input  wire logic              i_psel,       // apb select
   input  wire logic              i_penable,    // apb enable
   input  wire logic              i_pwrite,     // apb direction
   input  wire logic [11:0]       i_paddr,      // apb byte address
   input  wire logic [31:0]       i_pwdata,     // apb write data
   output logic                   o_pready,     // apb ready
   output logic      [31:0]       o_prdata,     // apb read data
   output logic                   o_pslverr,    // unmapped address
   // shared indicator / configuration pins
   input  wire logic [2:0]        i_cfg_pin,    // pin levels in
   output logic      [2:0]        o_led_pin,    // indicator drive
   output logic      [2:0]        o_led_oe,     // high while driving
   // line side, from receive/transmit logic on this clock
   input  wire logic              i_pause,      // advertise pause
   input  wire logic              i_flp_rx,     // partner page received
   input  wire psms_abil_s        i_lp_abil,    // partner abilities
   input  wire logic              i_nlp_seen,   // normal link pulses
   input  wire logic              i_idle_seen,  // 100 Mbps idle symbols
   input  wire logic              i_link_fail,  // link failure state
   output logic                   o_send_flp,   // send flp bursts
   output logic      [4:0]        o_adv_word,   // {pause, abilities}
   output psms_link_s             o_link,       // resolved link mode
   output logic                   o_in_reset    // extended reset active
);
   import psms_pkg::*;

   logic [2:0]        cfg_sync;
   logic [2:0]        cfg_r;
   logic [31:0]       ctrl_r;
   logic [31:0]       ledcfg_r;
   logic [CNT_W-1:0]  ext_cnt_r;
   logic              pdet_r;
   logic              ext_done;
   logic              wr_ctrl;
   psms_state_e       state_r;
   psms_abil_s        common;

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   psms_pin_sync #(.W(3)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_pin      (i_cfg_pin),
      .o_level    (cfg_sync)
   );

   // ----------------------------------------------------------------
   // apb slave: one access cycle, registered answer
   // ----------------------------------------------------------------
   assign wr_ctrl = i_psel && i_penable && i_pwrite && i_paddr == ADDR_CTRL;
   // answer registered in setup so outputs come from flip-flops
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         if (i_psel && !i_penable) begin
            case (i_paddr)
               ADDR_CTRL:   o_prdata <= ctrl_r;
               ADDR_LEDCFG: o_prdata <= ledcfg_r;
               ADDR_STATUS: begin
                  o_prdata[ST_CFG_LSB +: 3]   <= cfg_r;
                  o_prdata[ST_STATE_LSB +: 3] <= state_r;
                  o_prdata[ST_LINK]           <= o_link.link_up;
                  o_prdata[ST_SPD]            <= o_link.speed100;
                  o_prdata[ST_DPX]            <= o_link.full_duplex;
                  o_prdata[ST_PDET]           <= pdet_r;
               end
               default: o_pslverr <= 1'b1;
            endcase
         end
      end
   end

   // writes land at the access edge, where the master samples pready
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_r <= 32'h0000_0000;
      end else begin
         // software reset bit
         // a write setting the bit wins over hardware clearing it
         if (ext_done && state_r == S_RESET) begin
            ctrl_r[CTRL_SWRST] <= 1'b0;
         end
         ctrl_r[CTRL_RESTART] <= 1'b0;  // self-clearing restart strobe
         if (wr_ctrl) begin
            ctrl_r[CTRL_SWRST]   <= i_pwdata[CTRL_SWRST]
                                    | ctrl_r[CTRL_SWRST];
            ctrl_r[CTRL_RESTART] <= i_pwdata[CTRL_RESTART];
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ledcfg_r <= LEDCFG_RST;
      end else if (i_psel && i_penable && i_pwrite
                   && i_paddr == ADDR_LEDCFG) begin
         ledcfg_r <= i_pwdata & 32'h0000_0777;
      end
   end

   // ----------------------------------------------------------------
   // reset extension
   // ----------------------------------------------------------------
   assign ext_done = ext_cnt_r == CNT_W'(RST_EXT - 1);

   // extend reset; software bit restarts the count
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_cnt_r <= '0;
      end else if (ctrl_r[CTRL_SWRST] && state_r != S_RESET) begin
         ext_cnt_r <= '0;
      end else if (state_r == S_RESET && !ext_done) begin
         ext_cnt_r <= ext_cnt_r + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   // modes offered by both ourselves and the partner
   assign common = i_lp_abil & OWN_ABIL;

   // sample pins, then forced or automatic
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= S_RESET;
         cfg_r   <= 3'h0;
         pdet_r  <= 1'b0;
         o_link  <= '0;
      end else if (ctrl_r[CTRL_SWRST] && state_r != S_RESET) begin
         state_r <= S_RESET;
         o_link  <= '0;
      end else begin
         case (state_r)
            S_RESET: begin
               // latch pins once the extended reset ends
               if (ext_done && !ctrl_r[CTRL_SWRST]) begin
                  cfg_r   <= cfg_sync;
                  state_r <= S_SAMPLE;
               end
            end
            S_SAMPLE: begin
               // automatic unless pins force a mode
               pdet_r <= 1'b0;
               state_r <= cfg_r[CFG_AUTO] ? S_NEG : S_FORCED;
            end
            S_FORCED: begin
               o_link.speed100    <= cfg_r[CFG_SPD];
               o_link.full_duplex <= cfg_r[CFG_DPX];
               o_link.link_up     <= 1'b1;
               state_r            <= S_LINK;
            end
            S_NEG: begin
               // partner page resolves the best common mode
               if (i_flp_rx && common != '0) begin
                  o_link.speed100    <= common.fd100 | common.hd100;
                  o_link.full_duplex <= common.fd100
                                        | (common.fd10 & !common.hd100);
                  o_link.link_up     <= 1'b1;
                  state_r            <= S_LINK;
               // parallel detection of a plain partner
               end else if (i_idle_seen) begin
                  o_link  <= '{link_up: 1'b1, speed100: 1'b1,
                               full_duplex: 1'b0};
                  pdet_r  <= 1'b1;
                  state_r <= S_LINK;
               end else if (i_nlp_seen) begin
                  o_link  <= '{link_up: 1'b1, speed100: 1'b0,
                               full_duplex: 1'b0};
                  pdet_r  <= 1'b1;
                  state_r <= S_LINK;
               end
            end
            S_LINK: begin
               if (i_link_fail || ctrl_r[CTRL_RESTART]) begin
                  o_link  <= '0;
                  state_r <= S_SAMPLE;
               end
            end
            default: state_r <= S_RESET;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_send_flp <= 1'b0;
         o_adv_word <= 5'h00;
         o_in_reset <= 1'b1;
      end else begin
         o_send_flp <= state_r == S_NEG;
         o_adv_word <= {i_pause, OWN_ABIL};
         o_in_reset <= state_r == S_RESET;
      end
   end

   // ----------------------------------------------------------------
   // indicator drive, one per pin
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 3; k++) begin : g_led
      logic [2:0] sel;
      logic       lvl;
      assign sel = ledcfg_r[k*LED_SEL_STEP +: LED_SEL_W];
      always_comb begin
         case (sel)
            LED_ON:     lvl = 1'b1;
            LED_LINK:   lvl = o_link.link_up;
            LED_SPEED:  lvl = o_link.speed100;
            LED_DUPLEX: lvl = o_link.full_duplex;
            LED_NEG:    lvl = state_r == S_NEG;
            default:    lvl = 1'b0;
         endcase
      end
      // pin is input during reset, indicator afterwards
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            o_led_pin[k] <= 1'b0;
            o_led_oe[k]  <= 1'b0;
         end else begin
            o_led_pin[k] <= lvl;
            o_led_oe[k]  <= state_r != S_RESET;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   pin_latch_a: assert property (
      state_r == S_RESET ##1 state_r == S_SAMPLE |-> cfg_r == $past(cfg_sync))
      else $error("config not latched from pins");
   auto_path_a: assert property (
      state_r == S_SAMPLE && !ctrl_r[CTRL_SWRST]
      |=> state_r == (cfg_r[CFG_AUTO] ? S_NEG : S_FORCED))
      else $error("wrong mode path after sampling");
   flp_send_a: assert property (
      state_r == S_NEG |=> o_send_flp)
      else $error("bursts not sent while negotiating");
   pdet_idle_a: assert property (
      state_r == S_NEG && !(i_flp_rx && common != '0) && i_idle_seen
      && !(ctrl_r[CTRL_SWRST])
      |=> o_link.speed100 && o_link.link_up && pdet_r)
      else $error("idle symbols did not select 100 Mbps");
   forced_mode_a: assert property (
      state_r == S_FORCED && !ctrl_r[CTRL_SWRST]
      |=> o_link.full_duplex == cfg_r[CFG_DPX]
          && o_link.speed100 == cfg_r[CFG_SPD])
      else $error("forced duplex or speed wrong");
   led_drive_a: assert property (
      ledcfg_r[2:0] == LED_LINK && state_r != S_RESET
      ##1 ledcfg_r[2:0] == LED_LINK |-> o_led_pin[0] == $past(o_link.link_up))
      else $error("indicator does not follow link");
   pin_input_a: assert property (
      state_r == S_RESET |=> o_led_oe == 3'h0)
      else $error("pins driven during reset");
   rst_extend_a: assert property (
      $rose(o_in_reset) |-> o_in_reset [*8])
      else $error("reset extension too short");
   pause_adv_a: assert property (
      1'b1 |=> o_adv_word[4] == $past(i_pause))
      else $error("pause not advertised");
   fail_eval_a: assert property (
      state_r == S_LINK && i_link_fail && !ctrl_r[CTRL_SWRST]
      |=> state_r == S_SAMPLE ##1 state_r inside {S_NEG, S_FORCED})
      else $error("link failure did not re-evaluate");
   drive_after_a: assert property (
      state_r == S_SAMPLE |=> o_led_oe == 3'h7)
      else $error("pins not switched to drive");
endmodule

// ==== psms_pkg.sv ====
// package: constants, types and register map of the start-up mode selector
package psms_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 100;  // core clock rate
   localparam int unsigned RST_EXT_US   = 258;  // reset extension, us
   localparam int unsigned RST_EXT_CYC  = RST_EXT_US * CLK_MHZ;
   localparam int unsigned CNT_W        = 16;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_LEDCFG  = 12'h004;
   localparam logic [11:0] ADDR_STATUS  = 12'h008;

   // ctrl fields
   localparam int unsigned CTRL_SWRST   = 0;
   localparam int unsigned CTRL_RESTART = 1;
   // led select field: 3 bits per indicator, 4 bits apart
   localparam int unsigned LED_SEL_W    = 3;
   localparam int unsigned LED_SEL_STEP = 4;
   localparam logic [31:0] LEDCFG_RST   = 32'h0000_0432;
   // status fields
   localparam int unsigned ST_CFG_LSB   = 0;
   localparam int unsigned ST_STATE_LSB = 4;
   localparam int unsigned ST_LINK      = 8;
   localparam int unsigned ST_SPD       = 9;
   localparam int unsigned ST_DPX       = 10;
   localparam int unsigned ST_PDET      = 11;

   // configuration pin encoding
   localparam int unsigned CFG_SPD      = 0;  // forced: 1 = 100 Mbps
   localparam int unsigned CFG_DPX      = 1;  // forced: 1 = full duplex
   localparam int unsigned CFG_AUTO     = 2;  // 1 = automatic mode

   // indicator selections
   localparam logic [2:0] LED_OFF       = 3'h0;
   localparam logic [2:0] LED_ON        = 3'h1;
   localparam logic [2:0] LED_LINK      = 3'h2;
   localparam logic [2:0] LED_SPEED     = 3'h3;
   localparam logic [2:0] LED_DUPLEX    = 3'h4;
   localparam logic [2:0] LED_NEG       = 3'h5;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_RESET  = 3'h0,
      S_SAMPLE = 3'h1,
      S_FORCED = 3'h2,
      S_NEG    = 3'h3,
      S_LINK   = 3'h4
   } psms_state_e;

   // technology abilities, both ours and the partner's
   typedef struct packed {
      logic fd100;
      logic hd100;
      logic fd10;
      logic hd10;
   } psms_abil_s;

   typedef struct packed {
      logic link_up;
      logic speed100;
      logic full_duplex;
   } psms_link_s;

   localparam psms_abil_s OWN_ABIL = 4'hF;  // all four modes
endpackage

// ==== psms_pin_sync.sv ====
// three-stage synchroniser with agreement filter for external pins
`timescale 1ns/1ns
module psms_pin_sync #(
   parameter int unsigned W = 3
) (
   input  wire logic         i_core_clk, // core clock
   input  wire logic         i_rstn,     // async reset, active low
   input  wire logic [W-1:0] i_pin,      // raw pin levels
   output logic      [W-1:0] o_level     // filtered level
);
   // ----------------------------------------------------------------
   // per-bit stages
   // ----------------------------------------------------------------
   for (genvar b = 0; b < W; b++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // first stage feeds only the second; output moves once 2 and 3 agree
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            s1_r       <= 1'b0;
            s2_r       <= 1'b0;
            s3_r       <= 1'b0;
            o_level[b] <= 1'b0;
         end else begin
            s1_r <= i_pin[b];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
               o_level[b] <= s3_r;
            end
         end
      end
   end
endmodule

// ==== psms_link_partner.sv ====
// far-end link partner model: negotiates, or shows pulses or idle only
`timescale 1ns/1ns
module psms_link_partner
   import psms_pkg::*;
(
   input  wire logic                 i_core_clk,  // core clock
   input  wire logic                 i_rstn,      // async reset, active low
   input  wire logic [1:0]           i_mode,      // 0 neg, 1 idle, 2 pulses
   input  wire psms_pkg::psms_abil_s i_abil,      // abilities to offer
   input  wire logic                 i_fail,      // request a link failure
   input  wire logic                 i_send_flp,  // local side bursting
   output logic                      o_flp_rx,    // page received pulse
   output psms_pkg::psms_abil_s      o_lp_abil,   // page contents
   output logic                      o_nlp_seen,  // 10 Mbps pulses seen
   output logic                      o_idle_seen, // 100 Mbps idle seen
   output logic                      o_link_fail  // link failure level
);
   import psms_pkg::*;
   logic [2:0] burst_r;
   // --------------------------------------------------------------
   // negotiation answer
   // --------------------------------------------------------------
   // answer bursts with a page
   // a page is valid only in its pulse; otherwise the word churns so a
   // stale value can never pass for a fresh page
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         burst_r   <= 3'h0;
         o_flp_rx  <= 1'b0;
         o_lp_abil <= 4'h0;
      end else begin
         burst_r   <= (i_send_flp && i_mode == 2'h0) ?
                      ((burst_r == 3'h4) ? 3'h4 : burst_r + 3'h1) : 3'h0;
         o_flp_rx  <= (burst_r == 3'h3);
         o_lp_abil <= (burst_r == 3'h3) ? i_abil : ~o_lp_abil;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_nlp_seen  <= 1'b0;
         o_idle_seen <= 1'b0;
         o_link_fail <= 1'b0;
      end else begin
         o_nlp_seen  <= (i_mode == 2'h2);
         o_idle_seen <= (i_mode == 2'h1);
         o_link_fail <= i_fail;
      end
   end
endmodule

// ==== psms_top_bench.sv ====
// self-checking bench of the start-up mode selector over apb
`timescale 1ns/1ns
module psms_top_bench;
   import psms_pkg::*;
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] mask;
      logic        err;
   } psms_note_s;
   logic        i_core_clk = 0, i_rstn = 0, i_pause = 0;
   logic        i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic        o_pready, o_pslverr, o_send_flp, o_in_reset;
   logic [2:0]  o_led_pin, o_led_oe, pin_w, strap_r = 3'b011;
   logic [4:0]  o_adv_word;
   logic        flp_rx, nlp, idle, lfail, lp_fail = 0;
   logic [1:0]  lp_mode = 2'h0;
   logic [31:0] rnd;
   psms_abil_s  lp_abil = 4'h1, lp_word;
   psms_link_s  o_link;
   psms_note_s  note_r, notes[$];
   int          bad_count = 0, checks_done = 0, seed = 32'h53CE;
   always #5 i_core_clk = ~i_core_clk;
   // shared pins: the indicator drive wins over the strap resistor
   assign pin_w = (o_led_oe & o_led_pin) | (~o_led_oe & strap_r);
   psms_top #(.RST_EXT(20)) u_psms_top (.i_core_clk(i_core_clk),
      .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
      .i_cfg_pin(pin_w), .o_led_pin(o_led_pin), .o_led_oe(o_led_oe),
      .i_pause(i_pause), .i_flp_rx(flp_rx), .i_lp_abil(lp_word),
      .i_nlp_seen(nlp), .i_idle_seen(idle), .i_link_fail(lfail),
      .o_send_flp(o_send_flp), .o_adv_word(o_adv_word),
      .o_link(o_link), .o_in_reset(o_in_reset));
   psms_link_partner u_psms_link_partner (.i_core_clk(i_core_clk),
      .i_rstn(i_rstn), .i_mode(lp_mode), .i_abil(lp_abil),
      .i_fail(lp_fail), .i_send_flp(o_send_flp), .o_flp_rx(flp_rx),
      .o_lp_abil(lp_word), .o_nlp_seen(nlp), .o_idle_seen(idle),
      .o_link_fail(lfail));
   // --------------------------------------------------------------
   // checking and bus tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, e, m, input logic er);
      int n;
      notes.push_back(psms_note_s'{e, m, er});
      @(posedge i_core_clk);
      i_psel    <= 1'b1;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, 0);
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // bounded wait until a watched flag reaches a level
   task automatic wait_for(input int sel, input logic lvl);
      int n;
      n = 0;
      while (n < 300 && (sel == 0 ? o_in_reset : sel == 1 ?
             o_link.link_up : o_send_flp) !== lvl) begin
         @(posedge i_core_clk);
         n++;
      end
      if (n >= 300) chk("wait", 1, 0);
   endtask
   // read data is judged at the very edge the master takes it
   always @(posedge i_core_clk) begin
      if (o_pready === 1'b1) begin
         note_r = notes.pop_front();
         chk("prdata", note_r.exp & note_r.mask, o_prdata & note_r.mask);
         chk("pslverr", note_r.err, o_pslverr);
      end
   end
   function automatic logic [2:0] best(input psms_abil_s a);
      if (a.fd100) return 3'b111;
      if (a.hd100) return 3'b110;
      if (a.fd10) return 3'b101;
      return 3'b100;
   endfunction
   // status word: {pdet, duplex, speed, link} above the latched pins
   function automatic logic [31:0] st(input logic pd, input logic [2:0] l);
      return {20'h0, pd, l[0], l[1], l[2], 8'h04};
   endfunction
   task automatic conclude;
      $display("counts: checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   initial begin
      repeat (10) @(posedge i_core_clk);
      chk("in_reset", 1, o_in_reset);
      chk("led_oe", 0, o_led_oe);
      repeat (10) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      wait_for(0, 0);
      wait_for(1, 1);
      chk("forced", 3'b111, o_link);
      apb(0, ADDR_LEDCFG, 0, LEDCFG_RST, 32'hFFFFFFFF, 0);
      apb(0, ADDR_STATUS, 0, 32'h703, 32'hF07, 0);
      apb(1, 12'h00C, 32'h5, 0, 0, 1);
      apb(0, 12'h00C, 0, 0, 32'hFFFFFFFF, 1);
      $display("test forced start done");
      // forced 100 full, not negotiating: off on link spd dpx neg
      for (int c = 0; c < 6; c++) begin
         apb(1, ADDR_LEDCFG, 32'h430 | c, 0, 0, 0);
         repeat (4) @(posedge i_core_clk);
         chk("led_a", (32'h1E >> c) & 32'h1, o_led_pin[0]);
         chk("led_bc", 3'b11, o_led_pin[2:1]);
         chk("led_oe", 3'b111, o_led_oe);
      end
      $display("test indicator codes done");
      strap_r <= 3'b100;
      for (int r = 0; r < 3; r++) begin
         rnd = $random(seed);
         lp_abil <= (rnd[3:0] == 4'h0) ? 4'h1 : rnd[3:0];
         i_pause <= rnd[4];
         apb(1, ADDR_CTRL, 32'h1, 0, 0, 0);
         repeat (3) @(posedge i_core_clk);
         chk("sw_reset", 1, o_in_reset);
         wait_for(0, 0);
         wait_for(2, 1);
         chk("adv", {rnd[4], 4'hF}, o_adv_word);
         wait_for(1, 1);
         chk("neg", best(lp_abil), o_link);
         apb(0, ADDR_STATUS, 0, st(0, best(lp_abil)), 32'hF07, 0);
      end
      $display("test negotiation done");
      for (int p = 1; p < 3; p++) begin
         lp_mode <= p[1:0];
         lp_fail <= 1'b1;
         @(posedge i_core_clk);
         lp_fail <= 1'b0;
         wait_for(1, 0);
         wait_for(1, 1);
         chk("pdet", p == 1 ? 3'b110 : 3'b100, o_link);
         apb(0, ADDR_STATUS, 0, st(1, p == 1 ? 3'b110 : 3'b100),
             32'hF07, 0);
      end
      $display("test parallel detection done");
      // restart strobe re-runs selection on the latched automatic setting
      apb(1, ADDR_CTRL, 32'h2, 0, 0, 0);
      wait_for(1, 0);
      wait_for(1, 1);
      chk("restart", 3'b100, o_link);
      apb(0, ADDR_CTRL, 0, 0, 32'h3, 0);
      $display("test restart done");
      repeat (4) @(posedge i_core_clk);
      conclude();
   end
   // watchdog sized well past the whole sequence
   initial begin
      #200000;
      chk("timeout", 1, 0);
      conclude();
   end
endmodule
